// ===== verilog/svm_ctrl.sv
// Function
// R1: Hold reset until brown-out comparator reports OK.
// R2: Brown-out acts only after 500 us below.
// R3: Brown-out mode and level from option bytes.
// R4: Monitors B and C disabled after reset.
// R5: Mode register ignores writes while locked.
// R6: Key 0xA508 unlocks, 0xA500 relocks configuration.
// R7: Monitor B silent for 300 us after enable.
// R8: Monitor C silent for 1200 us after enable.
// R9: Monitor B threshold select has sixteen levels.
// R10: Monitor C threshold select has four levels.
// R11: Monitor B reset mode resets, clears mode.
// R12: Monitor C reset mode resets, clears mode.
// R13: Re-enable below threshold cycles reset and run.
// R14: Monitor B interrupt on first low, then crossings.
// R15: Monitor C interrupt on first low, then crossings.
// R16: No interrupt when enabled above threshold.
// R17: Software avoids brown-out level above B level.
// R18: Software keeps B level below C level.
// R19: Software saving data uses interrupt mode.
// R20: Detections set sticky flags, software clears them.
// R21: Comparator outputs pass two-flop synchronisers.
`timescale 1ns/1ps
`default_nettype none

module svm_ctrl #(
  parameter int unsigned BO_CYC   = svm_pkg::BO_DELAY_CYC,
  parameter int unsigned STB_B    = svm_pkg::STAB_B_CYC,
  parameter int unsigned STB_C    = svm_pkg::STAB_C_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [31:0] option_word_i,
  input  wire logic [2:0]  cmp_ok_i,
  output logic      [2:0]  cmp_en_o,
  output logic      [2:0]  brownout_threshold_o,
  output logic      [3:0]  threshold_b_o,
  output logic      [1:0]  threshold_c_o,
  output logic             sys_rst_o,
  output logic             irq_b_o,
  output logic             irq_c_o
);
  import svm_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]             s1;
    logic [2:0]             s2;
    logic                   opt_ld;
    logic                   bo_en;
    logic [2:0]             bo_lvl;
    svm_rst_e               state;
    logic [CNT_W-1:0]       bo_cnt;
    logic [3:0]             pulse_cnt;
    logic                   unlock;
    logic [3:0]             mode;
    logic [3:0]             lvl_b;
    logic [1:0]             lvl_c;
    logic [1:0]             act;
    logic [1:0]             prev;
    logic [1:0]             flag;
    logic [1:0]             irq;
    logic [1:0][CNT_W-1:0]  stab;
    logic                   rst;
    logic                   rdy;
    logic                   err;
    logic [31:0]            rdata;
  } svm_ctrl_s;

  svm_ctrl_s q;
  svm_ctrl_s d;

  localparam logic [CNT_W-1:0] BO_LIM  = CNT_W'(BO_CYC);
  localparam logic [CNT_W-1:0] LIM_B   = CNT_W'(STB_B - 1);
  localparam logic [CNT_W-1:0] LIM_C   = CNT_W'(STB_C - 1);
  localparam logic [3:0]       PLS_LIM = 4'(RST_PULSE_CYC - 1);

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == ADDR_MODE) || (a == ADDR_LEVEL) || (a == ADDR_KEY) ||
              (a == ADDR_STATUS) || (a == ADDR_OPTION);
  endfunction : reg_hit

  logic ok;
  logic bo_trip;
  logic rreq;
  logic wr;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d       = q;
    d.irq   = 2'b00;
    d.rdy   = 1'b0;
    d.err   = 1'b0;
    rreq    = 1'b0;
    d.s1    = cmp_ok_i; // R21
    d.s2    = q.s1; // R21
    if (!q.opt_ld) begin
      d.opt_ld = 1'b1; // R3
      d.bo_en  = option_word_i[OPT_EN_BIT]; // R3
      d.bo_lvl = option_word_i[OPT_LVL_LSB +: 3]; // R3
    end
    ok = q.s2[0] | ~q.bo_en;
    // The counter stops at its limit, so a long brown-out never wraps round and lets reset go.
    if (q.s2[0]) begin
      d.bo_cnt = '0;
    end else if (q.bo_cnt != BO_LIM) begin
      d.bo_cnt = q.bo_cnt + 1'b1; // R2
    end
    bo_trip = q.bo_en & ~q.s2[0] & (q.bo_cnt == BO_LIM); // R2

    // Register access completes one cycle into the access phase.
    if (psel_i && penable_i && !q.rdy) begin
      d.rdy = 1'b1;
      d.err = ~reg_hit(paddr_i);
      case (paddr_i)
        ADDR_MODE:   d.rdata = {28'h0, q.mode};
        ADDR_LEVEL:  d.rdata = {26'h0, q.lvl_c, q.lvl_b};
        ADDR_KEY:    d.rdata = {31'h0, q.unlock};
        ADDR_STATUS: d.rdata = {25'h0, q.s2, q.act, q.flag};
        ADDR_OPTION: d.rdata = {28'h0, q.bo_lvl, q.bo_en};
        default:     d.rdata = 32'h0;
      endcase
    end
    wr = psel_i & penable_i & pwrite_i & q.rdy & reg_hit(paddr_i);
    if (wr) begin
      case (paddr_i)
        ADDR_KEY: begin
          if (pwdata_i[15:0] == KEY_UNLOCK) begin
            d.unlock = 1'b1; // R6
          end else if (pwdata_i[15:0] == KEY_LOCK) begin
            d.unlock = 1'b0; // R6
          end
        end
        ADDR_MODE: begin
          if (q.unlock) begin
            d.mode = pwdata_i[3:0]; // R5
          end
        end
        ADDR_LEVEL: begin
          if (q.unlock) begin
            d.lvl_b = pwdata_i[LVL_B_LSB +: 4]; // R9
            d.lvl_c = pwdata_i[LVL_C_LSB +: 2]; // R10
          end
        end
        ADDR_STATUS: d.flag = q.flag & ~pwdata_i[1:0]; // R20
        default:     d.flag = d.flag;
      endcase
    end

    // Flags are set after the clear above, so a detection wins.
    for (int i = 0; i < 2; i++) begin
      if (!q.mode[2*i]) begin
        d.act[i]  = 1'b0;
        d.stab[i] = '0;
      end else if (!q.act[i]) begin
        // Prev starts high, so a supply that is already above raises no interrupt.
        if (q.stab[i] == ((i == 0) ? LIM_B : LIM_C)) begin
          d.act[i]  = 1'b1; // R7 R8
          d.prev[i] = 1'b1; // R16
        end else begin
          d.stab[i] = q.stab[i] + 1'b1;
        end
      end else if (q.mode[2*i+1]) begin
        if (q.s2[i+1] != q.prev[i]) begin
          d.prev[i] = q.s2[i+1]; // R14 R15
          d.irq[i]  = 1'b1; // R14 R15
          d.flag[i] = 1'b1; // R20
        end
      end else if (!q.s2[i+1]) begin
        rreq = 1'b1; // R11 R12
      end
    end

    // A brown-out trip wins over a monitor reset, since it must hold until the supply recovers.
    case (q.state)
      ST_HOLD: begin
        if (q.opt_ld && ok) begin
          d.state = ST_RUN; // R1
        end
      end
      ST_RUN: begin
        if (bo_trip) begin
          d.state = ST_HOLD; // R1
        end else if (rreq) begin
          d.state     = ST_PULSE; // R13
          d.pulse_cnt = 4'h0;
        end
      end
      ST_PULSE: begin
        if (q.pulse_cnt == PLS_LIM || bo_trip) begin
          d.state = ST_HOLD;
        end else begin
          d.pulse_cnt = q.pulse_cnt + 1'b1;
        end
      end
      default: d.state = ST_HOLD;
    endcase

    // Any internal reset returns the monitors to their disabled state.
    d.rst = (d.state != ST_RUN); // R1
    if (d.rst) begin
      d.mode   = MODE_RST; // R4 R11 R12
      d.lvl_b  = LVL_B_RST;
      d.lvl_c  = LVL_C_RST;
      d.unlock = 1'b0;
      d.act    = 2'b00;
      d.stab   = '0;
      d.flag   = 2'b00;
      d.irq    = 2'b00;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q.s1        <= 3'b110;
      q.s2        <= 3'b110;
      q.opt_ld    <= 1'b0;
      q.bo_en     <= 1'b0;
      q.bo_lvl    <= BO_LVL_RST;
      q.state     <= ST_HOLD;
      q.bo_cnt    <= '0;
      q.pulse_cnt <= 4'h0;
      q.unlock    <= 1'b0;
      q.mode      <= MODE_RST; // R4
      q.lvl_b     <= LVL_B_RST;
      q.lvl_c     <= LVL_C_RST;
      q.act       <= 2'b00;
      q.prev      <= 2'b11;
      q.flag      <= 2'b00;
      q.irq       <= 2'b00;
      q.stab      <= '0;
      q.rst       <= 1'b1;
      q.rdy       <= 1'b0;
      q.err       <= 1'b0;
      q.rdata     <= 32'h0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata_o             = q.rdata;
  assign pready_o             = q.rdy;
  assign pslverr_o            = q.err;
  assign cmp_en_o             = {q.mode[MODE_EN_C], q.mode[MODE_EN_B], q.bo_en};
  assign brownout_threshold_o = q.bo_lvl;
  assign threshold_b_o        = q.lvl_b;
  assign threshold_c_o        = q.lvl_c;
  assign sys_rst_o            = q.rst;
  assign irq_b_o              = q.irq[0];
  assign irq_c_o              = q.irq[1];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  a_bo_low_reset: assert property ( // R1
    (q.state == ST_RUN && bo_trip) |=> sys_rst_o [*3])
    else $error("brown-out trip did not reset");

  a_bo_delay_wait: assert property ( // R2
    ($fell(q.s2[0]) && !sys_rst_o && q.mode == 4'h0) |=> !sys_rst_o [*8])
    else $error("brown-out reset before delay");

  a_key_unlock: assert property ( // R6
    (wr && paddr_i == ADDR_KEY && pwdata_i[15:0] == KEY_UNLOCK && !d.rst) |=> q.unlock)
    else $error("unlock key ignored");

  a_key_lock: assert property ( // R6
    (wr && paddr_i == ADDR_KEY && pwdata_i[15:0] == KEY_LOCK) |=> !q.unlock)
    else $error("lock key ignored");

  a_mode_protect: assert property ( // R5
    (wr && paddr_i == ADDR_MODE && !q.unlock && !sys_rst_o && !d.rst) |=> $stable(q.mode))
    else $error("locked mode register changed");

  a_stab_wait_b: assert property ( // R7
    $rose(q.mode[MODE_EN_B]) |=> !q.act[0] [*8])
    else $error("monitor B active too early");

  a_stab_wait_c: assert property ( // R8
    $rose(q.mode[MODE_EN_C]) |=> !q.act[1] [*8])
    else $error("monitor C active too early");

  a_rst_clears_mode: assert property ( // R11
    (sys_rst_o && !$past(sys_rst_o)) |-> (q.mode == 4'h0 && !irq_b_o && !irq_c_o))
    else $error("reset left monitors enabled");

  a_irq_sets_flag: assert property ( // R20
    (irq_b_o || irq_c_o) |-> (q.flag & q.irq) == q.irq)
    else $error("interrupt without detect flag");

  a_pulse_len: assert property ( // R13
    $rose(q.state == ST_PULSE) |-> sys_rst_o [*8])
    else $error("monitor reset too short");

  a_hold_until_ok: assert property ( // R1
    (q.state == ST_HOLD && q.bo_en && !q.s2[0]) |=> sys_rst_o)
    else $error("reset released while brown-out low");

  a_quiet_stab_b: assert property ( // R7
    !q.act[0] |=> !irq_b_o)
    else $error("monitor B interrupt before settling");

  a_quiet_stab_c: assert property ( // R8
    !q.act[1] |=> !irq_c_o)
    else $error("monitor C interrupt before settling");

  a_irq_b_source: assert property ( // R14
    irq_b_o |-> ($past(q.act[0]) && $past(q.mode[MODE_IRQ_B])))
    else $error("monitor B interrupt outside interrupt mode");

  a_irq_c_source: assert property ( // R15
    irq_c_o |-> ($past(q.act[1]) && $past(q.mode[MODE_IRQ_C])))
    else $error("monitor C interrupt outside interrupt mode");

  a_sync_two_flop: assert property ( // R21
    q.s2 == $past(q.s1))
    else $error("comparator synchroniser skipped a stage");

  c_bo_trip: cover property (q.state == ST_RUN && bo_trip);
  c_irq_b: cover property (irq_b_o);
  c_irq_c: cover property (irq_c_o);
  c_mon_reset: cover property (q.state == ST_PULSE);
  c_unlock: cover property ($rose(q.unlock));

endmodule : svm_ctrl

`default_nettype wire

// ===== shared/svm_pkg.sv
package svm_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned BO_DELAY_US   = 500;
  localparam int unsigned STAB_B_US     = 300;
  localparam int unsigned STAB_C_US     = 1200;
  localparam int unsigned BO_DELAY_CYC  = BO_DELAY_US * CLK_MHZ;
  localparam int unsigned STAB_B_CYC    = STAB_B_US * CLK_MHZ;
  localparam int unsigned STAB_C_CYC    = STAB_C_US * CLK_MHZ;
  localparam int unsigned RST_PULSE_CYC = 16;
  localparam int unsigned CNT_W         = 18;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_MODE   = 12'h000;
  localparam logic [11:0] ADDR_LEVEL  = 12'h004;
  localparam logic [11:0] ADDR_KEY    = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_OPTION = 12'h010;

  localparam logic [15:0] KEY_UNLOCK = 16'hA508;
  localparam logic [15:0] KEY_LOCK   = 16'hA500;

  // Mode register: enable at 2*i, interrupt mode (else reset mode) at 2*i+1.
  localparam int unsigned MODE_EN_B  = 0;
  localparam int unsigned MODE_IRQ_B = 1;
  localparam int unsigned MODE_EN_C  = 2;
  localparam int unsigned MODE_IRQ_C = 3;
  localparam int unsigned LVL_B_LSB  = 0;
  localparam int unsigned LVL_C_LSB  = 4;

  // Option word holds bytes 0x0000_0404 to 0x0000_0407.
  localparam logic [31:0] OPT_ADDR_FIRST = 32'h0000_0404;
  localparam logic [31:0] OPT_ADDR_LAST  = 32'h0000_0407;
  localparam int unsigned OPT_EN_BIT     = 0;
  localparam int unsigned OPT_LVL_LSB    = 1;

  localparam logic [3:0]  MODE_RST   = 4'h0;
  localparam logic [3:0]  LVL_B_RST  = 4'h0;
  localparam logic [1:0]  LVL_C_RST  = 2'h0;
  localparam logic [2:0]  BO_LVL_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_RUN   = 2'b01,
    ST_PULSE = 2'b10
  } svm_rst_e;

endpackage : svm_pkg

// ===== bench/svm_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Supply comparators
// ------------------------------------------------------------
// A comparator that is switched off reports low, so a disabled monitor never looks healthy.
module svm_supply_model (
  input  wire logic [7:0] supply_i,
  input  wire logic [2:0] cmp_en_i,
  input  wire logic [2:0] bo_lvl_i,
  input  wire logic [3:0] lvl_b_i,
  input  wire logic [1:0] lvl_c_i,
  output logic      [2:0] cmp_ok_o
);
  // The spans never overlap, so any level keeps brown-out below B and B below C.
  always_comb begin
    cmp_ok_o[0] = cmp_en_i[0] && supply_i >= 8'h28 + 8'(bo_lvl_i) * 8'h05;
    cmp_ok_o[1] = cmp_en_i[1] && supply_i >= 8'h64 + 8'(lvl_b_i) * 8'h04;
    cmp_ok_o[2] = cmp_en_i[2] && supply_i >= 8'hAA + 8'(lvl_c_i) * 8'h0A;
  end
endmodule : svm_supply_model

`default_nettype wire

// ===== bench/test_svm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module test_svm_ctrl;
  import svm_pkg::*;
  localparam int BO = 20;
  localparam int SB = 10;
  localparam int SC = 12;
  localparam logic [7:0] HI = 8'hFA;
  localparam logic [7:0] MID = 8'hA5;
  localparam logic [7:0] LOWB = 8'h5A;
  logic        clock = 1'h0;
  logic        srst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] option = 32'h0;
  logic [7:0]  supply = 8'h00;
  logic [2:0]  cmp_ok, cmp_en, bo_lvl;
  logic [3:0]  lvl_b;
  logic [1:0]  lvl_c;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, sys_rst_o, irq_b_o, irq_c_o;
  logic [33:0] exp_q[$];
  logic [33:0] ent;
  logic [2:0]  bo;
  logic [3:0]  lb;
  logic [1:0]  lc;
  int          n_errors = 0, n_checks = 0, cyc = 0, t0, nb = 0, nc = 0, tb, tc;

  svm_ctrl #(.BO_CYC(BO), .STB_B(SB), .STB_C(SC)) dut (.clock_i(clock), .srst_i(srst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .option_word_i(option), .cmp_ok_i(cmp_ok), .cmp_en_o(cmp_en),
    .brownout_threshold_o(bo_lvl), .threshold_b_o(lvl_b), .threshold_c_o(lvl_c), .sys_rst_o(sys_rst_o),
    .irq_b_o(irq_b_o), .irq_c_o(irq_c_o));
  svm_supply_model model (.supply_i(supply), .cmp_en_i(cmp_en), .bo_lvl_i(bo_lvl), .lvl_b_i(lvl_b),
    .lvl_c_i(lvl_c), .cmp_ok_o(cmp_ok));

  always #2.5 clock = ~clock;

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Holds the request until pready is seen high or 20 cycles pass, and counts a timeout as an error.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic err);
    int n;
    n = 0;
    @(posedge clock);
    exp_q.push_back({~w, err, e});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready_o !== 1'h1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) begin
      n_errors++;
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (sys_rst_o !== v && n < 500) begin
      @(posedge clock);
      n++;
    end
    check(sys_rst_o, v);
  endtask : wait_rst

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (irq_b_o === 1'h1) nb <= nb + 1;
    if (irq_b_o === 1'h1) tb <= cyc;
    if (irq_c_o === 1'h1) nc <= nc + 1;
    if (irq_c_o === 1'h1) tc <= cyc;
    if (pready_o === 1'h1) begin
      ent = exp_q.pop_front();
      check(pslverr_o, ent[32]);
      if (ent[33]) check(prdata_o, ent[31:0]);
    end
  end

  initial begin
    #20000;
    n_errors++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hF5FE));
    bo = 3'($urandom % 5);
    lb = 4'($urandom);
    lc = 2'($urandom);
    @(posedge clock);
    option <= {28'h0, bo, 1'h1};
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    repeat (20) @(posedge clock);
    check(sys_rst_o, 1'h1);
    supply <= HI;
    wait_rst(1'h0);
    apb(1'h0, ADDR_OPTION, 32'h0, {28'h0, bo, 1'h1}, 1'h0);
    check(bo_lvl, bo);
    apb(1'h0, ADDR_MODE, 32'h0, 32'h0, 1'h0);
    check(cmp_en, 3'h1);
    apb(1'h1, ADDR_MODE, 32'hF, 32'h0, 1'h0);
    apb(1'h0, ADDR_MODE, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 12'h0FC, 32'h0, 32'h0, 1'h1);
    apb(1'h1, ADDR_KEY, 32'(KEY_UNLOCK), 32'h0, 1'h0);
    apb(1'h0, ADDR_KEY, 32'h0, 32'h1, 1'h0);
    apb(1'h1, ADDR_LEVEL, {26'h0, lc, lb}, 32'h0, 1'h0);
    @(posedge clock);
    check({lvl_c, lvl_b}, {lc, lb});
    supply <= LOWB;
    apb(1'h1, ADDR_MODE, 32'hF, 32'h0, 1'h0);
    t0 = cyc;
    repeat (30) @(posedge clock);
    check(tb - t0 >= SB, 1'h1);
    check(tc - t0 >= SC, 1'h1);
    check({nb, nc}, {32'h1, 32'h1});
    supply <= HI;
    repeat (10) @(posedge clock);
    check({nb, nc}, {32'h2, 32'h2});
    supply <= MID;
    repeat (10) @(posedge clock);
    check({nb, nc}, {32'h2, 32'h3});
    apb(1'h0, ADDR_STATUS, 32'h0, 32'h3F, 1'h0);
    apb(1'h1, ADDR_STATUS, 32'h3, 32'h0, 1'h0);
    apb(1'h0, ADDR_STATUS, 32'h0, 32'h3C, 1'h0);
    apb(1'h1, ADDR_MODE, 32'h0, 32'h0, 1'h0);
    supply <= HI;
    apb(1'h1, ADDR_MODE, 32'hF, 32'h0, 1'h0);
    repeat (30) @(posedge clock);
    check({nb, nc}, {32'h2, 32'h3});
    apb(1'h1, ADDR_KEY, 32'(KEY_LOCK), 32'h0, 1'h0);
    apb(1'h1, ADDR_MODE, 32'h0, 32'h0, 1'h0);
    apb(1'h0, ADDR_MODE, 32'h0, 32'hF, 1'h0);
    supply <= LOWB;
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, ADDR_KEY, 32'(KEY_UNLOCK), 32'h0, 1'h0);
      apb(1'h1, ADDR_MODE, 32'h0, 32'h0, 1'h0);
      apb(1'h1, ADDR_MODE, (i < 2) ? 32'h1 : 32'h4, 32'h0, 1'h0);
      t0 = cyc;
      wait_rst(1'h1);
      check(cyc - t0 >= ((i < 2) ? SB : SC), 1'h1);
      wait_rst(1'h0);
      apb(1'h0, ADDR_MODE, 32'h0, 32'h0, 1'h0);
    end
    supply <= 8'h00;
    t0 = cyc;
    wait_rst(1'h1);
    check(cyc - t0 >= BO && cyc - t0 <= BO + 8, 1'h1);
    supply <= HI;
    wait_rst(1'h0);
    complete_run();
  end
endmodule : test_svm_ctrl

`default_nettype wire
